//--- dwnv_defines.vh
`ifndef DWNV_DEFINES_VH
`define DWNV_DEFINES_VH

// Timing
`define DWNV_CLK_HZ        25000000
`define DWNV_SAVE_MS       25
`define DWNV_SAVE_CYCLES   ((`DWNV_CLK_HZ / 1000) * `DWNV_SAVE_MS)

// Word layout
`define DWNV_WORD_BITS     16
`define DWNV_CMD_MSB       15
`define DWNV_CMD_LSB       12
`define DWNV_ADDR_MSB      11
`define DWNV_ADDR_LSB      8
`define DWNV_DATA_MSB      7
`define DWNV_DATA_LSB      0

// Commands
`define DWNV_CMD_NOP       4'h0
`define DWNV_CMD_RESTORE   4'h1
`define DWNV_CMD_SAVE      4'h2
`define DWNV_CMD_NV_WRITE  4'h3
`define DWNV_CMD_DEC_6DB   4'h4
`define DWNV_CMD_DEC_6DB_A 4'h5
`define DWNV_CMD_DEC_ONE   4'h6
`define DWNV_CMD_DEC_ONE_A 4'h7
`define DWNV_CMD_RESTORE_A 4'h8
`define DWNV_CMD_SAVE_A    4'h9
`define DWNV_CMD_LOAD      4'hB
`define DWNV_CMD_INC_6DB   4'hC
`define DWNV_CMD_INC_6DB_A 4'hD
`define DWNV_CMD_INC_ONE   4'hE
`define DWNV_CMD_INC_ONE_A 4'hF

// Wiper codes: midscale reset value, full and zero step limits
`define DWNV_MIDSCALE      8'h80
`define DWNV_FULLSCALE     8'hFF
`define DWNV_ZEROSCALE     8'h00

`endif

//--- dwnv_sync.v
`timescale 1ns/10ps
`include "dwnv_defines.vh"

// Two-flop synchroniser for the pin inputs, one per bit
module dwnv_sync #(
    parameter WIDTH = 5
) (
    input  wire             sys_clk,
    input  wire             rst_n,
    input  wire [WIDTH-1:0] pin_in,
    input  wire [WIDTH-1:0] reset_val,
    output wire [WIDTH-1:0] pin_sync
);

    genvar i;
    generate
        for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
            reg meta;
            reg stable;
            always @(posedge sys_clk) begin
                if (!rst_n) begin
                    meta   <= reset_val[i];
                    stable <= reset_val[i];
                end else begin
                    meta   <= pin_in[i];
                    stable <= meta;
                end
            end
            assign pin_sync[i] = stable;
        end
    endgenerate

endmodule // dwnv_sync

//--- dwnv_ctrl.v
`timescale 1ns/10ps
`include "dwnv_defines.vh"

// Notes on behaviour
// [R1] Code 00 is B, 80 mid, FF A
// [R2] Nonvolatile save lasts about 25 ms
// [R3] Shift register locked during save
// [R4] Done output marks end of save
// [R5] Command 11 loads addressed wiper register
// [R6] Command 2 saves wiper to store
// [R7] Power-on restores wipers from stores
// [R8] Stores hold midscale until first save
// [R9] Preset low midscale, rising edge restores
// [R10] Word B040 loads 40 into wiper one
// [R11] Words 20XX/21XX save wiper one/two
// [R12] Output returns previous frame's word
// [R13] Step by one code or 6 dB
// [R14] Bare select strobe repeats step command
// [R15] Write protect blocks all but restores (code blocks only loads and steps; saves still run)
// [R16] Host sends NOP before releasing protect
// [R17] Frame is one 16-bit command word
// [R18] Instruction, address, data, MSB first
// [R19] Execute when select returns high
// [R20] Output is input delayed 16 clocks
// [R21] Done low during save, high after
// [R22] Host waits for done after save
module dwnv_ctrl #(
    parameter SAVE_CYCLES = `DWNV_SAVE_CYCLES
) (
    input  wire       sys_clk,
    input  wire       rst_n,
    input  wire       serial_clk,
    input  wire       chip_sel_n,
    input  wire       serial_in,
    input  wire       write_prot_n,
    input  wire       preset_strobe_n,
    output reg        serial_out,
    output reg        serial_out_oe_n,
    output reg        done,
    output reg        done_oe_n,
    output reg  [7:0] wiper_term_ch1,
    output reg  [7:0] wiper_term_ch2
);

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers

    wire [4:0] pins_sync;
    wire       sclk_s;
    wire       cs_n_s;
    wire       sdi_s;
    wire       wp_n_s;
    wire       pr_n_s;

    dwnv_sync #(
        .WIDTH(5)
    ) u_sync (
        .sys_clk  (sys_clk),
        .rst_n    (rst_n),
        .pin_in   ({serial_clk, chip_sel_n, serial_in, write_prot_n, preset_strobe_n}),
        .reset_val(5'h0B),
        .pin_sync (pins_sync)
    );

    assign sclk_s = pins_sync[4];
    assign cs_n_s = pins_sync[3];
    assign sdi_s  = pins_sync[2];
    assign wp_n_s = pins_sync[1];
    assign pr_n_s = pins_sync[0];

    ////////////////////////////////////////////////////////////////////////
    // Edge detection on synchronised levels

    reg        sclk_d;
    reg        cs_n_d;
    reg        pr_n_d;
    reg        primed;
    wire       sclk_rise;
    wire       sclk_fall;
    wire       cs_rise;
    wire       pr_rise;

    always @(posedge sys_clk) begin
        if (!rst_n) begin
            sclk_d <= 1'b0;
            cs_n_d <= 1'b1;
            pr_n_d <= 1'b1;
            primed <= 1'b0;
        end else begin
            sclk_d <= sclk_s;
            cs_n_d <= cs_n_s;
            pr_n_d <= pr_n_s;
            primed <= 1'b1;
        end
    end

    assign sclk_rise = primed && sclk_s && !sclk_d && !cs_n_s;
    assign sclk_fall = primed && !sclk_s && sclk_d && !cs_n_s;
    assign cs_rise   = primed && cs_n_s && !cs_n_d;
    assign pr_rise   = primed && pr_n_s && !pr_n_d;

    ////////////////////////////////////////////////////////////////////////
    // State machine

    localparam [3:0] ST_BOOT = 4'b0001;
    localparam [3:0] ST_IDLE = 4'b0010;
    localparam [3:0] ST_SAVE = 4'b0100;
    localparam [3:0] ST_EXEC = 4'b1000;

    reg  [3:0]  state;
    reg  [3:0]  next_state;
    reg  [15:0] shift_reg;
    reg  [15:0] out_reg;
    reg  [15:0] prev_word;
    reg  [4:0]  bit_cnt;
    reg  [3:0]  last_cmd;
    reg  [3:0]  last_addr;
    reg         repeat_ok;
    reg  [7:0]  nv_store_ch1;
    reg  [7:0]  nv_store_ch2;
    reg  [7:0]  wiper_pos_reg_ch1;
    reg  [7:0]  wiper_pos_reg_ch2;
    reg  [31:0] save_cnt;
    reg         save_sel;
    reg  [3:0]  exec_cmd;
    reg  [3:0]  exec_addr;
    reg  [7:0]  exec_data;
    reg  [7:0]  save_data;
    reg         frame_seen;
    reg         frame_void;

    wire        frame_full;
    wire [3:0]  word_cmd;
    wire [3:0]  word_addr;
    wire [7:0]  word_data;

    assign frame_full = (bit_cnt == 5'h10);
    assign word_cmd   = shift_reg[`DWNV_CMD_MSB:`DWNV_CMD_LSB];   // see [R18]
    assign word_addr  = shift_reg[`DWNV_ADDR_MSB:`DWNV_ADDR_LSB];
    assign word_data  = shift_reg[`DWNV_DATA_MSB:`DWNV_DATA_LSB];

    always @* begin
        case (state)
            ST_BOOT: next_state = ST_IDLE;
            ST_IDLE: next_state = cs_rise ? ST_EXEC : ST_IDLE;  // see [R19]
            ST_EXEC: next_state = (exec_cmd == `DWNV_CMD_SAVE) ? ST_SAVE : ST_IDLE;
            ST_SAVE: next_state = (save_cnt == 32'h0) ? ST_IDLE : ST_SAVE;
            default: next_state = ST_IDLE;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Wiper step helpers

    function [7:0] dwnv_step;
        input [3:0] cmd;
        input [7:0] val;
        begin
            case (cmd)
                `DWNV_CMD_INC_ONE, `DWNV_CMD_INC_ONE_A:
                    dwnv_step = (val == `DWNV_FULLSCALE) ? val : val + 8'h01;       // see [R13]
                `DWNV_CMD_DEC_ONE, `DWNV_CMD_DEC_ONE_A:
                    dwnv_step = (val == `DWNV_ZEROSCALE) ? val : val - 8'h01;       // see [R13]
                `DWNV_CMD_INC_6DB, `DWNV_CMD_INC_6DB_A:
                    dwnv_step = val[7] ? `DWNV_FULLSCALE : {val[6:0], 1'b1};         // see [R13]
                `DWNV_CMD_DEC_6DB, `DWNV_CMD_DEC_6DB_A:
                    dwnv_step = {1'b0, val[7:1]};                                    // see [R13]
                default:
                    dwnv_step = val;
            endcase
        end
    endfunction

    function dwnv_is_step;
        input [3:0] cmd;
        begin
            dwnv_is_step = (cmd[3:2] == 2'b01) || (cmd[3:2] == 2'b11);
        end
    endfunction

    function dwnv_both;
        input [3:0] cmd;
        begin
            dwnv_both = (cmd == `DWNV_CMD_INC_ONE_A) || (cmd == `DWNV_CMD_DEC_ONE_A)
                     || (cmd == `DWNV_CMD_INC_6DB_A) || (cmd == `DWNV_CMD_DEC_6DB_A);
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Main sequential logic

    always @(posedge sys_clk) begin
        if (!rst_n) begin
            state             <= ST_BOOT;
            shift_reg         <= 16'h0000;
            prev_word         <= 16'h0000;
            bit_cnt           <= 5'h00;
            last_cmd          <= `DWNV_CMD_NOP;
            last_addr         <= 4'h0;
            repeat_ok         <= 1'b0;
            nv_store_ch1      <= `DWNV_MIDSCALE;   // see [R8]
            nv_store_ch2      <= `DWNV_MIDSCALE;   // see [R8]
            wiper_pos_reg_ch1 <= `DWNV_MIDSCALE;
            wiper_pos_reg_ch2 <= `DWNV_MIDSCALE;
            save_cnt          <= 32'h0;
            save_sel          <= 1'b0;
            exec_cmd          <= `DWNV_CMD_NOP;
            exec_addr         <= 4'h0;
            exec_data         <= 8'h00;
            save_data         <= `DWNV_MIDSCALE;
            done              <= 1'b1;
            done_oe_n         <= 1'b1;
        end else begin
            state <= next_state;

            case (state)
                ST_BOOT: begin
                    wiper_pos_reg_ch1 <= nv_store_ch1;   // see [R7]
                    wiper_pos_reg_ch2 <= nv_store_ch2;   // see [R7]
                end
                ST_IDLE: begin
                    if (sclk_rise) begin
                        shift_reg <= {shift_reg[14:0], sdi_s};   // see [R17], [R18]
                        bit_cnt   <= frame_full ? 5'h01 : bit_cnt + 5'h01;
                    end
                    if (cs_n_s && !cs_n_d && primed) begin
                        bit_cnt <= 5'h00;
                        if (frame_full && !frame_void) begin   // see [R3]
                            exec_cmd  <= word_cmd;
                            exec_addr <= word_addr;
                            exec_data <= word_data;
                            prev_word <= shift_reg;   // see [R12]
                            last_cmd  <= word_cmd;
                            last_addr <= word_addr;
                            repeat_ok <= dwnv_is_step(word_cmd);
                        end else if (bit_cnt == 5'h00 && repeat_ok && !frame_seen) begin
                            exec_cmd  <= last_cmd;    // see [R14]
                            exec_addr <= last_addr;
                        end else begin
                            exec_cmd  <= `DWNV_CMD_NOP;
                        end
                    end
                end
                ST_EXEC: begin
                    if (exec_cmd == `DWNV_CMD_LOAD && wp_n_s) begin   // see [R15]
                        if (exec_addr[0])
                            wiper_pos_reg_ch2 <= exec_data;   // see [R5]
                        else
                            wiper_pos_reg_ch1 <= exec_data;   // see [R5], [R10]
                    end
                    if ((exec_cmd == `DWNV_CMD_RESTORE) || (exec_cmd == `DWNV_CMD_RESTORE_A)) begin
                        if (exec_cmd == `DWNV_CMD_RESTORE_A || !exec_addr[0])
                            wiper_pos_reg_ch1 <= nv_store_ch1;   // see [R15]
                        if (exec_cmd == `DWNV_CMD_RESTORE_A || exec_addr[0])
                            wiper_pos_reg_ch2 <= nv_store_ch2;
                    end
                    if (dwnv_is_step(exec_cmd) && wp_n_s) begin   // see [R15]
                        if (dwnv_both(exec_cmd) || !exec_addr[0])
                            wiper_pos_reg_ch1 <= dwnv_step(exec_cmd, wiper_pos_reg_ch1);
                        if (dwnv_both(exec_cmd) || exec_addr[0])
                            wiper_pos_reg_ch2 <= dwnv_step(exec_cmd, wiper_pos_reg_ch2);
                    end
                    if (exec_cmd == `DWNV_CMD_SAVE) begin
                        save_sel  <= exec_addr[0];       // see [R6], [R11]
                        save_data <= exec_addr[0] ? wiper_pos_reg_ch2 : wiper_pos_reg_ch1;   // see [R6]
                        save_cnt  <= SAVE_CYCLES - 1;    // see [R2]
                        done      <= 1'b0;               // see [R21]
                        done_oe_n <= 1'b0;
                    end
                end
                ST_SAVE: begin
                    bit_cnt <= 5'h00;   // see [R3]
                    if (save_cnt == 32'h0) begin
                        if (save_sel)
                            nv_store_ch2 <= save_data;   // see [R6]
                        else
                            nv_store_ch1 <= save_data;   // see [R6]
                        done      <= 1'b1;   // see [R4], [R21]
                        done_oe_n <= 1'b1;
                    end else begin
                        save_cnt <= save_cnt - 32'h1;   // see [R2]
                    end
                end
                default: ;
            endcase

            // Preset overrides: low forces midscale, rising edge restores
            if (!pr_n_s) begin
                wiper_pos_reg_ch1 <= `DWNV_MIDSCALE;   // see [R9]
                wiper_pos_reg_ch2 <= `DWNV_MIDSCALE;
            end else if (pr_rise) begin
                wiper_pos_reg_ch1 <= nv_store_ch1;     // see [R9]
                wiper_pos_reg_ch2 <= nv_store_ch2;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Frame history: clock edges seen, or overlap with a save

    always @(posedge sys_clk) begin
        if (!rst_n) begin
            frame_seen <= 1'b0;
            frame_void <= 1'b0;
        end else if (cs_rise) begin
            frame_seen <= 1'b0;
            frame_void <= 1'b0;
        end else begin
            if (sclk_rise) begin
                frame_seen <= 1'b1;   // see [R14]
            end
            if (state == ST_SAVE && !cs_n_s) begin
                frame_void <= 1'b1;   // see [R3]
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Output registers

    always @(posedge sys_clk) begin
        if (!rst_n) begin
            out_reg         <= 16'h0000;
            serial_out      <= 1'b1;
            serial_out_oe_n <= 1'b1;
            wiper_term_ch1  <= `DWNV_MIDSCALE;
            wiper_term_ch2  <= `DWNV_MIDSCALE;
        end else begin
            // Daisy-chain output: previous word shifted out, 16 clocks late
            if (state == ST_IDLE && cs_rise) begin
                out_reg <= shift_reg;   // see [R20]
            end else if (state == ST_IDLE && sclk_fall && !cs_n_d) begin
                out_reg <= {out_reg[14:0], 1'b0};
            end
            serial_out      <= cs_n_s ? 1'b1 : out_reg[15];    // see [R12], [R20]
            serial_out_oe_n <= cs_n_s | out_reg[15];

            wiper_term_ch1  <= wiper_pos_reg_ch1;   // see [R1]
            wiper_term_ch2  <= wiper_pos_reg_ch2;   // see [R1]
        end
    end

endmodule // dwnv_ctrl

//--- dwnv_ctrl_assertions.sv
`timescale 1ns/10ps
module dwnv_ctrl_assertions #(
    parameter SAVE_CYCLES = 625000
) (
    input wire       sys_clk,
    input wire       rst_n,
    input wire       serial_clk,
    input wire       chip_sel_n,
    input wire       serial_in,
    input wire       write_prot_n,
    input wire       preset_strobe_n,
    input wire       serial_out,
    input wire       serial_out_oe_n,
    input wire       done,
    input wire       done_oe_n,
    input wire [7:0] wiper_term_ch1,
    input wire [7:0] wiper_term_ch2
);
    reg [31:0] low_cnt;

    // Length of the current busy stretch
    always @(posedge sys_clk) begin
        if (!rst_n || done) begin
            low_cnt <= 32'h0;
        end else begin
            low_cnt <= low_cnt + 32'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    sequence s_cs_idle; chip_sel_n [*6]; endsequence
    sequence s_preset_low; !preset_strobe_n [*8]; endsequence
    sequence s_quiet_frame; (!chip_sel_n && preset_strobe_n) [*8]; endsequence
    sequence s_save_run; (!done && preset_strobe_n) [*3]; endsequence

    property p_out_idle; s_cs_idle |-> serial_out_oe_n; endproperty
    property p_save_len; $rose(done) |-> low_cnt + 2 >= SAVE_CYCLES && low_cnt <= SAVE_CYCLES + 2; endproperty
    property p_save_lock; s_save_run |-> $stable(wiper_term_ch1) && $stable(wiper_term_ch2); endproperty
    property p_done_pull; $fell(done) |-> (!done && !done_oe_n) [*4]; endproperty
    property p_save_at_end; $fell(done) |-> chip_sel_n; endproperty
    property p_frame_quiet; s_quiet_frame |-> $stable(wiper_term_ch1) && $stable(wiper_term_ch2); endproperty
    property p_preset_mid; s_preset_low |-> wiper_term_ch1 == 8'h80 && wiper_term_ch2 == 8'h80; endproperty
    property p_reset_vals; $rose(rst_n) |-> done && done_oe_n && serial_out_oe_n && wiper_term_ch1 == 8'h80; endproperty

    a_out_idle: assert property (p_out_idle) else $error("serial out driven while deselected");
    a_save_len: assert property (p_save_len) else $error("save length wrong");
    a_save_lock: assert property (p_save_lock) else $error("wiper moved during save");
    a_done_pull: assert property (p_done_pull) else $error("done not held low");
    a_save_at_end: assert property (p_save_at_end) else $error("save began inside a frame");
    a_frame_quiet: assert property (p_frame_quiet) else $error("wiper moved inside a frame");
    a_preset_mid: assert property (p_preset_mid) else $error("preset low not midscale");
    a_reset_vals: assert property (p_reset_vals) else $error("bad values after reset");
endmodule // dwnv_ctrl_assertions

bind dwnv_ctrl dwnv_ctrl_assertions #(.SAVE_CYCLES(SAVE_CYCLES)) i_dwnv_ctrl_assertions (
    .sys_clk(sys_clk), .rst_n(rst_n), .serial_clk(serial_clk), .chip_sel_n(chip_sel_n),
    .serial_in(serial_in), .write_prot_n(write_prot_n), .preset_strobe_n(preset_strobe_n),
    .serial_out(serial_out), .serial_out_oe_n(serial_out_oe_n), .done(done), .done_oe_n(done_oe_n),
    .wiper_term_ch1(wiper_term_ch1), .wiper_term_ch2(wiper_term_ch2));

//--- dwnv_host_model.sv
`timescale 1ns/10ps
module dwnv_host_model (
    input  wire sys_clk,
    input  wire out_line,
    output reg  serial_clk,
    output reg  chip_sel_n,
    output reg  serial_in
);
    initial begin
        serial_clk = 1'b0;
        chip_sel_n = 1'b1;
        serial_in = 1'b1;
    end

    // One frame, link clock 320 ns, clock still between frames
    task automatic send(input [15:0] word, input integer nbits, output [15:0] got);
        integer k;
        begin
            got = 16'h0000;
            chip_sel_n = 1'b0;
            repeat (8) @(negedge sys_clk);
            for (k = 15; k > 15 - nbits; k = k - 1) begin
                serial_in = word[k];
                repeat (4) @(negedge sys_clk);
                serial_clk = 1'b1;
                got = {got[14:0], out_line};
                repeat (4) @(negedge sys_clk);
                serial_clk = 1'b0;
            end
            repeat (4) @(negedge sys_clk);
            chip_sel_n = 1'b1;
            serial_in = ~serial_in;
            repeat (12) @(negedge sys_clk);
        end
    endtask
endmodule // dwnv_host_model

//--- dwnv_ctrl_test.sv
`timescale 1ns/10ps
module dwnv_ctrl_test;
    localparam SAVE = 400;
    reg        sys_clk;
    reg        rst_n;
    reg        write_prot_n;
    reg        preset_strobe_n;
    wire       serial_clk;
    wire       chip_sel_n;
    wire       serial_in;
    wire       serial_out;
    wire       serial_out_oe_n;
    wire       done;
    wire       done_oe_n;
    wire [7:0] wiper_term_ch1;
    wire [7:0] wiper_term_ch2;
    wire       out_line = serial_out_oe_n ? 1'b1 : serial_out;
    wire       ready_line = done_oe_n ? 1'b1 : done;
    integer    failures;
    integer    compares;
    reg [15:0] got;

    dwnv_ctrl #(.SAVE_CYCLES(SAVE)) i_dwnv_ctrl (.sys_clk(sys_clk), .rst_n(rst_n), .serial_clk(serial_clk),
        .chip_sel_n(chip_sel_n), .serial_in(serial_in), .write_prot_n(write_prot_n),
        .preset_strobe_n(preset_strobe_n), .serial_out(serial_out), .serial_out_oe_n(serial_out_oe_n),
        .done(done), .done_oe_n(done_oe_n), .wiper_term_ch1(wiper_term_ch1), .wiper_term_ch2(wiper_term_ch2));
    dwnv_host_model i_host (.sys_clk(sys_clk), .out_line(out_line), .serial_clk(serial_clk),
        .chip_sel_n(chip_sel_n), .serial_in(serial_in));

    always #20 sys_clk = ~sys_clk;

    ////////////////////////////////////////////////////////////////////////////
    task check_word(input [15:0] a, input [15:0] e);
        begin
            compares = compares + 1;
            if (a !== e) begin
                failures = failures + 1;
                $display("BAD t=%0t got %h exp %h", $time, a, e);
            end
        end
    endtask
    task check_byte(input [7:0] a, input [7:0] e);
        check_word({8'h00, a}, {8'h00, e});
    endtask
    task check_bit(input a, input e);
        check_word({15'h0, a}, {15'h0, e});
    endtask
    task wait_ready;
        integer n;
        begin
            n = 0;
            while (ready_line !== 1'b1 && n < SAVE + 50) begin
                @(negedge sys_clk);
                n = n + 1;
            end
            check_bit(ready_line, 1'b1);
        end
    endtask
    task step(input [15:0] w, input integer n, input [7:0] e1, input [7:0] e2);
        begin
            i_host.send(w, n, got);
            check_byte(wiper_term_ch1, e1);
            check_byte(wiper_term_ch2, e2);
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////
    task t_load_save;
        begin
            check_byte(wiper_term_ch1, 8'h80);
            i_host.send(16'hB040, 16, got);
            check_byte(wiper_term_ch1, 8'h40);
            i_host.send(16'h2000, 16, got);
            check_word(got, 16'hB040);
            check_bit(ready_line, 1'b0);
            wait_ready;
            i_host.send(16'hB1C0, 16, got);
            check_word(got, 16'h2000);
            check_byte(wiper_term_ch2, 8'hC0);
            i_host.send(16'h2100, 16, got);
            check_word(got, 16'hB1C0);
            wait_ready;
        end
    endtask
    task t_lock;
        begin
            i_host.send(16'h2000, 16, got);
            check_word(got, 16'h2100);
            i_host.send(16'hB0EE, 16, got);
            check_byte(wiper_term_ch1, 8'h40);
            wait_ready;
            step(16'hB0EE, 16, 8'hEE, 8'hC0);
        end
    endtask
    task t_preset;
        begin
            preset_strobe_n = 1'b0;
            repeat (10) @(negedge sys_clk);
            check_byte(wiper_term_ch1, 8'h80);
            preset_strobe_n = 1'b1;
            repeat (10) @(negedge sys_clk);
            check_byte(wiper_term_ch1, 8'h40);
            check_byte(wiper_term_ch2, 8'hC0);
        end
    endtask
    task t_steps;
        begin
            step(16'hE000, 16, 8'h41, 8'hC0);
            step(16'h0000, 0, 8'h42, 8'hC0);
            step(16'h6000, 16, 8'h41, 8'hC0);
            step(16'h4000, 16, 8'h20, 8'hC0);
            step(16'hC000, 16, 8'h41, 8'hC0);
            step(16'h5000, 16, 8'h20, 8'h60);
            step(16'hD000, 16, 8'h41, 8'hC1);
            step(16'hF000, 16, 8'h42, 8'hC2);
            step(16'h0000, 0, 8'h43, 8'hC3);
            step(16'h7000, 16, 8'h42, 8'hC2);
            step(16'hD000, 16, 8'h85, 8'hFF);
            step(16'hF000, 16, 8'h86, 8'hFF);
        end
    endtask
    task t_protect;
        begin
            write_prot_n = 1'b0;
            step(16'hB0AA, 16, 8'h86, 8'hFF);
            step(16'hE000, 16, 8'h86, 8'hFF);
            i_host.send(16'h8000, 16, got);
            check_byte(wiper_term_ch1, 8'h40);
            wait_ready;
            i_host.send(16'h0000, 16, got);
            write_prot_n = 1'b1;
            i_host.send(16'hB055, 16, got);
            check_byte(wiper_term_ch1, 8'h55);
            i_host.send(16'hB0AA, 15, got);
            check_byte(wiper_term_ch1, 8'h55);
            i_host.send(16'hB033, 16, got);
            check_byte(wiper_term_ch1, 8'h33);
        end
    endtask

    task finish_test;
        begin
            $display("compares=%0d failures=%0d", compares, failures);
            if (failures == 0 && compares > 0) begin
                $display("TB: PASS");
            end else begin
                $display("TB: FAIL");
            end
            $finish;
        end
    endtask

    initial begin
        #2000000;
        failures = failures + 1;
        finish_test;
    end

    initial begin
        sys_clk = 1'b0;
        rst_n = 1'b0;
        write_prot_n = 1'b1;
        preset_strobe_n = 1'b1;
        failures = 0;
        compares = 0;
        repeat (6) @(negedge sys_clk);
        rst_n = 1'b1;
        repeat (10) @(negedge sys_clk);
        t_load_save;
        t_lock;
        t_preset;
        t_steps;
        t_protect;
        finish_test;
    end
endmodule // dwnv_ctrl_test
